// *** core/rdm_pkg.sv ***
package rdm_pkg;

	// channel count and mode field width
	localparam int RDM_NUM_CH = 4;
	localparam int RDM_MODE_W = 2;

	// per-channel mode encodings
	localparam logic [1:0] RDM_MODE_OFF = 2'h0;
	localparam logic [1:0] RDM_MODE_PIN = 2'h1;
	localparam logic [1:0] RDM_MODE_ON = 2'h2;
	localparam logic [1:0] RDM_MODE_OFFDIAG = 2'h3;

	// register offsets, one aligned 32-bit word each
	localparam logic [3:0] RDM_OFS_MODE = 4'h0;
	localparam logic [3:0] RDM_OFS_STATUS = 4'h4;
	localparam logic [3:0] RDM_OFS_SUPPLY = 4'h8;

	// status field positions
	localparam int RDM_ST_PMODE_LSB = 0;
	localparam int RDM_ST_OUT_LSB = 4;
	localparam int RDM_ST_DIAG_LSB = 8;
	localparam int RDM_ST_CHAIN_BIT = 12;

	// reset values
	localparam logic [7:0] RDM_MODE_RST = 8'h00;
	localparam logic [31:0] RDM_UNMAPPED_RD = 32'h00000000;

	// serial clock ceiling in on mode
	localparam int RDM_SCLK_MAX_HZ = 5000000;

	typedef enum logic [1:0] {
		RDM_PWR_SLEEP,
		RDM_PWR_IDLE,
		RDM_PWR_ON
	} rdm_pwr_e;

	typedef enum logic [1:0] {
		RDM_BUS_IDLE,
		RDM_BUS_ACK
	} rdm_bus_e;

endpackage

// *** core/rdm_chan.sv ***
`timescale 1ns/1ns
module rdm_chan
	import rdm_pkg::*;
(
	input wire logic [1:0] mode_i, // this channel's mode field
	input wire logic pin_i, // direct-control pin level
	input wire logic enable_i, // device out of sleep and supplies up
	output logic out_o, // output switch drive
	output logic diag_o // diagnosis active for this channel
);

	// mode decode; the pin only counts in pin-follow mode
	always_comb begin
		out_o = 1'b0;
		diag_o = 1'b0;
		case (mode_i)
			RDM_MODE_OFF: begin
				out_o = 1'b0;
				diag_o = 1'b0;
			end
			RDM_MODE_PIN: begin
				out_o = pin_i;
				diag_o = 1'b1;
			end
			RDM_MODE_ON: begin
				out_o = 1'b1;
				diag_o = 1'b1;
			end
			default: begin
				out_o = 1'b0;
				diag_o = 1'b1;
			end
		endcase
		if (!enable_i) begin
			out_o = 1'b0;
			diag_o = 1'b0;
		end
	end

endmodule

// *** core/rdm_pwr.sv ***
`timescale 1ns/1ns
module rdm_pwr
	import rdm_pkg::*;
(
	input wire logic rst_pin_b_i, // reset pin level, low = sleep
	input wire logic supplies_ok_i, // both supplies out of power-on reset
	input wire logic any_active_i, // some channel not off-without-diagnosis
	output rdm_pwr_e pmode_o // current power mode
);

	// power mode is pure decode so it follows the pins without lag
	always_comb begin
		if (!rst_pin_b_i || !supplies_ok_i) begin
			pmode_o = RDM_PWR_SLEEP;
		end else if (any_active_i) begin
			pmode_o = RDM_PWR_ON;
		end else begin
			pmode_o = RDM_PWR_IDLE;
		end
	end

endmodule

// *** core/rdm_top.sv ***
`timescale 1ns/1ns
// How it works
// - supply power-on reset restores defaults, idle
// - low reset pin forces register defaults
// - low reset pin means sleep, all off
// - reset high, supplies up, all off: idle
// - on mode drives channels, clock at most 5MHz
// - daisy chain only with both supplies up
// - four channels each with own mode
// - off mode: output off, no diagnosis
// - all channels off means idle mode, except in sleep
// - pin mode follows direct-control pin level
// - pin high equals on, low equals off
// - forced-on mode ignores the pin
// - off-with-diagnosis: off, diagnosis kept active
// - floating direct-control pin reads as low
module rdm_top
	import rdm_pkg::*;
#(
	parameter int NUM_CH = RDM_NUM_CH
) (
	input wire logic core_clk_i, // serial-side clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic rst_pin_b_i, // device reset pin, active low
	input wire logic logic_por_ok_i, // logic supply out of power-on reset
	input wire logic analog_supply_rail_ok_i, // analog supply out of power-on reset
	input wire logic ctrl_pin_i, // direct-control pin level
	input wire logic ctrl_pin_oe_b_i, // low when something drives the pin
	input wire logic chain_si_i, // serial data in for pass-through
	output logic chain_so_o, // serial data out of pass-through
	input wire logic [3:0] avs_address_i, // byte address
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [31:0] avs_writedata_i, // write data
	input wire logic [3:0] avs_byteenable_i, // byte lanes
	output logic [31:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // stall
	output logic [NUM_CH-1:0] ch_out_o, // output switch drives
	output logic [NUM_CH-1:0] ch_diag_o, // diagnosis enables
	output logic [1:0] pmode_o // power mode code
);

	logic supplies_ok;
	logic dev_rst_b;
	logic pin_level;
	logic any_active;
	logic [NUM_CH-1:0] mode_nonoff;
	logic [RDM_MODE_W*NUM_CH-1:0] channel_mode_field_q;
	logic [RDM_MODE_W*NUM_CH-1:0] channel_mode_field_d;
	logic [NUM_CH-1:0] out_w;
	logic [NUM_CH-1:0] diag_w;
	rdm_pwr_e pmode;
	rdm_bus_e bus_q;
	rdm_bus_e bus_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [NUM_CH-1:0] out_q;
	logic [NUM_CH-1:0] diag_q;
	logic [1:0] pmode_q;
	logic chain_q;
	logic chain_d;

	// both rails must be out of power-on reset before anything runs
	assign supplies_ok = logic_por_ok_i & analog_supply_rail_ok_i;
	assign dev_rst_b = rst_pin_b_i & supplies_ok;

	// an undriven pin is pulled low by the input sink
	assign pin_level = ctrl_pin_i & ~ctrl_pin_oe_b_i;

	// per-channel decode; one instance per channel
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			rdm_chan u_chan (
				.mode_i(channel_mode_field_q[g*RDM_MODE_W +: RDM_MODE_W]),
				.pin_i(pin_level),
				.enable_i(dev_rst_b),
				.out_o(out_w[g]),
				.diag_o(diag_w[g])
			);
			assign mode_nonoff[g] =
				channel_mode_field_q[g*RDM_MODE_W +: RDM_MODE_W] != RDM_MODE_OFF;
		end
	endgenerate

	assign any_active = |mode_nonoff;

	rdm_pwr u_pwr (
		.rst_pin_b_i(rst_pin_b_i),
		.supplies_ok_i(supplies_ok),
		.any_active_i(any_active),
		.pmode_o(pmode)
	);

	// single wait state: waitrequest high in the request cycle, low the next
	always_comb begin
		bus_d = RDM_BUS_IDLE;
		case (bus_q)
			RDM_BUS_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					bus_d = RDM_BUS_ACK;
				end
			end
			default: begin
				bus_d = RDM_BUS_IDLE;
			end
		endcase
	end

	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && bus_q != RDM_BUS_ACK;

	// mode register: writes take effect on the ack edge, resets force defaults
	always_comb begin
		channel_mode_field_d = channel_mode_field_q;
		if (!dev_rst_b) begin
			channel_mode_field_d = RDM_MODE_RST;
		end else if (bus_q == RDM_BUS_ACK && avs_write_i && avs_byteenable_i[0]) begin
			if (avs_address_i == RDM_OFS_MODE) begin
				channel_mode_field_d = avs_writedata_i[RDM_MODE_W*NUM_CH-1:0];
			end
		end
	end

	// read data is captured in the request cycle so it stands at the ack edge
	always_comb begin
		rdata_d = RDM_UNMAPPED_RD;
		if (avs_address_i == RDM_OFS_MODE) begin
			rdata_d[RDM_MODE_W*NUM_CH-1:0] = channel_mode_field_q;
		end else if (avs_address_i == RDM_OFS_STATUS) begin
			rdata_d[RDM_ST_PMODE_LSB +: 2] = pmode;
			rdata_d[RDM_ST_OUT_LSB +: NUM_CH] = out_w;
			rdata_d[RDM_ST_DIAG_LSB +: NUM_CH] = diag_w;
			rdata_d[RDM_ST_CHAIN_BIT] = supplies_ok;
		end else if (avs_address_i == RDM_OFS_SUPPLY) begin
			rdata_d[0] = logic_por_ok_i;
			rdata_d[1] = analog_supply_rail_ok_i;
			rdata_d[2] = rst_pin_b_i;
		end
	end

	// pass-through only while both rails are good and the reset pin is high, otherwise held low
	always_comb begin
		chain_d = 1'b0;
		if (supplies_ok && rst_pin_b_i) begin
			chain_d = chain_si_i;
		end
	end

	// state registers
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus_q <= RDM_BUS_IDLE;
			channel_mode_field_q <= RDM_MODE_RST;
			rdata_q <= RDM_UNMAPPED_RD;
			out_q <= '0;
			diag_q <= '0;
			pmode_q <= 2'h0;
			chain_q <= 1'b0;
		end else begin
			bus_q <= bus_d;
			channel_mode_field_q <= channel_mode_field_d;
			rdata_q <= rdata_d;
			out_q <= out_w;
			diag_q <= diag_w;
			pmode_q <= pmode;
			chain_q <= chain_d;
		end
	end

	// data outputs come from flip-flops, one cycle behind the decode
	assign avs_readdata_o = rdata_q;
	assign ch_out_o = out_q;
	assign ch_diag_o = diag_q;
	assign pmode_o = pmode_q;
	assign chain_so_o = chain_q;

endmodule

// *** dv/rdm_top_assertions.sv ***
`timescale 1ns/1ns
module rdm_top_assertions #(
	parameter int NUM_CH = 4
) (
	input wire logic core_clk_i, // clock
	input wire logic rst_b_i, // async reset
	input wire logic rst_pin_b_i, // reset pin
	input wire logic logic_por_ok_i, // logic supply ok
	input wire logic analog_supply_rail_ok_i, // analog supply ok
	input wire logic chain_si_i, // chain in
	input wire logic chain_so_o, // chain out
	input wire logic avs_read_i, // read
	input wire logic avs_write_i, // write
	input wire logic avs_waitrequest_o, // stall
	input wire logic [NUM_CH-1:0] ch_out_o, // switches
	input wire logic [NUM_CH-1:0] ch_diag_o, // diagnosis
	input wire logic [1:0] pmode_o // power mode
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// supplies up is the gate for everything but sleep
	logic sup;
	assign sup = logic_por_ok_i && analog_supply_rail_ok_i;
	AST_SLEEP_PIN:
	assert property (!rst_pin_b_i |=> pmode_o == 2'h0 && ch_out_o == '0) else $error("no sleep");
	AST_POR_IDLE:
	assert property ($rose(sup) && rst_pin_b_i |=> pmode_o == 2'h1) else $error("not idle");
	AST_POR_SLEEP:
	assert property (!sup |=> pmode_o == 2'h0) else $error("por not sleep");
	AST_IDLE_OFF:
	assert property (pmode_o == 2'h1 |-> ch_out_o == '0 && ch_diag_o == '0) else $error("idle busy");
	AST_SLEEP_QUIET:
	assert property (pmode_o == 2'h0 |-> ch_out_o == '0 && ch_diag_o == '0) else $error("sleep busy");
	AST_OUT_ON:
	assert property (ch_out_o != '0 |-> pmode_o == 2'h2) else $error("out without on");
	AST_CHAIN_OFF:
	assert property (!sup |=> !chain_so_o) else $error("chain active");
	AST_CHAIN_PASS:
	assert property (sup && rst_pin_b_i |=> chain_so_o == $past(chain_si_i)) else $error("chain data");
	AST_WAIT_ONE:
	assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("wait state");
	// main scenarios reached
	cover property (pmode_o == 2'h2);
	cover property (ch_out_o != '0 && ch_diag_o != '0);
	cover property (chain_so_o);
endmodule
bind rdm_top rdm_top_assertions #(.NUM_CH(NUM_CH)) u_chk (.*);

// *** dv/rdm_mcu_model.sv ***
`timescale 1ns/1ns
module rdm_mcu_model (
	input wire logic core_clk_i, // clock
	input wire logic lvl_i, // level to drive
	input wire logic drv_i, // drive the pin
	output logic pin_o, // pin level
	output logic oe_b_o // low while driving
);
	logic last_q = 1'b0;
	// released pin shows the inverse of the last level, so ignoring oe is caught
	always_ff @(posedge core_clk_i) begin
		if (drv_i) last_q <= lvl_i;
	end
	assign oe_b_o = !drv_i;
	assign pin_o = drv_i ? lvl_i : !last_q;
endmodule

// *** dv/tb_rdm_top.sv ***
`timescale 1ns/1ns
module tb_rdm_top;
	import rdm_pkg::*;
	logic core_clk_i = 0, rst_b_i = 0, rst_pin_b_i = 1, lok = 1, aok = 1;
	logic lvl = 0, drv = 1, si = 0, rd = 0, wr = 0, pin, oe_b, so, wt;
	logic [3:0] addr = 4'h0, out, diag;
	logic [31:0] wd = 32'h0, rdata, got;
	logic [1:0] pm;
	int num_errors = 0, n_tests = 0;
	rdm_top dut (.core_clk_i, .rst_b_i, .rst_pin_b_i, .logic_por_ok_i(lok),
		.analog_supply_rail_ok_i(aok), .ctrl_pin_i(pin), .ctrl_pin_oe_b_i(oe_b),
		.chain_si_i(si), .chain_so_o(so), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wt), .ch_out_o(out),
		.ch_diag_o(diag), .pmode_o(pm));
	rdm_mcu_model mcu (.core_clk_i, .lvl_i(lvl), .drv_i(drv), .pin_o(pin), .oe_b_o(oe_b));
	// 100 MHz, twenty times the 5MHz serial ceiling; pins change at most once a cycle
	initial begin
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick();
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= d;
		do @(posedge core_clk_i); while (wt !== 1'b0);
		got = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic pins(input logic l, input logic d);
		@(posedge core_clk_i);
		lvl <= l;
		drv <= d;
		tick();
	endtask
	task automatic t_reset();
		check(pm, RDM_PWR_IDLE);
		bus(0, RDM_OFS_MODE, 0);
		check(got, RDM_MODE_RST);
		bus(0, 4'hC, 0);
		check(got, RDM_UNMAPPED_RD);
		bus(0, RDM_OFS_SUPPLY, 0);
		check(got, 32'h00000007);
	endtask
	task automatic t_modes();
		bus(1, RDM_OFS_MODE, 32'hE4);
		pins(1, 1);
		check(out, 4'h6);
		check(pm, RDM_PWR_ON);
		check({diag[3], diag[0]}, 2'h2);
		bus(0, RDM_OFS_STATUS, 0);
		check(got, 32'h00001E62);
		pins(0, 1);
		check(out, 4'h4);
		pins(1, 0);
		check(out, 4'h4);
		bus(0, RDM_OFS_MODE, 0);
		check(got, 32'hE4);
		bus(1, RDM_OFS_MODE, 0);
		tick();
		check({pm, diag, out}, {RDM_PWR_IDLE, 8'h00});
	endtask
	task automatic t_sleep();
		bus(1, RDM_OFS_MODE, 32'hAA);
		@(posedge core_clk_i);
		rst_pin_b_i <= 1'b0;
		// no bus traffic while the pin holds the device asleep
		tick();
		check({pm, diag, out}, 10'h000);
		@(posedge core_clk_i);
		rst_pin_b_i <= 1'b1;
		tick();
		bus(0, RDM_OFS_MODE, 0);
		check(got, 32'h0);
	endtask
	task automatic t_por();
		bus(1, RDM_OFS_MODE, 32'hAA);
		@(posedge core_clk_i);
		aok <= 1'b0;
		si <= 1'b1;
		tick();
		check({pm, so}, 3'h0);
		@(posedge core_clk_i);
		aok <= 1'b1;
		tick();
		check({pm, so}, 3'h3);
		bus(0, RDM_OFS_MODE, 0);
		check(got, 32'h0);
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// a hung handshake would never return
	initial begin
		#20000;
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		tick();
		t_reset();
		t_modes();
		t_sleep();
		t_por();
		complete_run();
	end
endmodule
